/* rtl/pcisig_pkg.sv */
package pcisig_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned AD_W   = 64;
    localparam int unsigned CBE_W  = 8;
    localparam int unsigned LO_W   = 32;

    // ----------------------------------------------------------------
    // Command register bit positions
    // ----------------------------------------------------------------
    localparam int unsigned CMD_PERR_EN_BIT = 6;
    localparam int unsigned CMD_SERR_EN_BIT = 8;
    localparam logic [15:0] CMD_RESET       = 16'h0000;

    // ----------------------------------------------------------------
    // Bus commands
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_MEM_READ  = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_CFG_READ  = 4'hA;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hB;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MAX_MHZ = 66;
    localparam int unsigned SYS_MHZ     = 20;
    localparam logic [3:0]  DEVSEL_TIMEOUT = 4'h5;

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ  = 3'b001,
        ST_ADDR = 3'b011,
        ST_DATA = 3'b010,
        ST_TURN = 3'b110
    } pcisig_state_e;

endpackage

/* rtl/pcisig_if.sv */
`timescale 1ns/1ps
// Shared bus: each driver has out and enable (serr and inta enable only); resolved with pull-ups
interface pcisig_if;
    logic [63:0] ad_o_dev, ad_o_hst, ad;
    logic [7:0]  cbe_o_dev, cbe_o_hst, cben;
    logic        ad_oe_dev, ad_oe_hst, ad64_oe_dev, ad64_oe_hst;
    logic        par_o_dev, par_o_hst, par_oe_dev, par_oe_hst, par;
    logic        par64_o_dev, par64_o_hst, par64;
    logic        framen_o, framen_oe, framen;
    logic        irdyn_o_dev, irdyn_o_hst, irdyn_oe_dev, irdyn_oe_hst, irdyn;
    logic        trdyn_o_dev, trdyn_o_hst, trdyn_oe_dev, trdyn_oe_hst, trdyn;
    logic        stopn_o, stopn_oe, stopn;
    logic        devseln_o, devseln_oe, devseln;
    logic        perrn_o, perrn_oe, perrn;
    logic        serrn_oe, serrn, intan_oe, intan;
    logic        reqn, gntn, idsel;
    logic        req64n_o_dev, req64n_o_hst, req64n_oe_dev, req64n_oe_hst, req64n;
    logic        ack64n_o, ack64n_oe, ack64n;
    logic        dev_frame_o, dev_frame_oe;

    assign ad[31:0]  = ad_oe_dev ? ad_o_dev[31:0] : ad_oe_hst ? ad_o_hst[31:0] : 32'hFFFFFFFF;
    assign ad[63:32] = ad64_oe_dev ? ad_o_dev[63:32]
                     : ad64_oe_hst ? ad_o_hst[63:32] : 32'hFFFFFFFF;
    assign cben[3:0] = ad_oe_dev ? cbe_o_dev[3:0] : ad_oe_hst ? cbe_o_hst[3:0] : 4'hF;
    assign cben[7:4] = ad64_oe_dev ? cbe_o_dev[7:4] : ad64_oe_hst ? cbe_o_hst[7:4] : 4'hF;
    assign par     = par_oe_dev ? par_o_dev : par_oe_hst ? par_o_hst : 1'b1;
    assign par64   = par_oe_dev ? par64_o_dev : par_oe_hst ? par64_o_hst : 1'b1;
    assign framen  = dev_frame_oe ? dev_frame_o : framen_oe ? framen_o : 1'b1;
    assign irdyn   = irdyn_oe_dev ? irdyn_o_dev : irdyn_oe_hst ? irdyn_o_hst : 1'b1;
    assign trdyn   = trdyn_oe_dev ? trdyn_o_dev : trdyn_oe_hst ? trdyn_o_hst : 1'b1;
    assign stopn   = stopn_oe ? stopn_o : 1'b1;
    assign devseln = devseln_oe ? devseln_o : 1'b1;
    assign perrn   = perrn_oe ? perrn_o : 1'b1;
    assign serrn   = serrn_oe ? 1'b0 : 1'b1;
    assign intan   = intan_oe ? 1'b0 : 1'b1;
    assign req64n  = req64n_oe_dev ? req64n_o_dev : req64n_oe_hst ? req64n_o_hst : 1'b1;
    assign ack64n  = ack64n_oe ? ack64n_o : 1'b1;

    modport dev (
        input  ad, cben, par, par64, framen, irdyn, trdyn, stopn, idsel, gntn, req64n, ack64n,
        output ad_o_dev, cbe_o_dev, ad_oe_dev, ad64_oe_dev, par_o_dev, par64_o_dev,
        output par_oe_dev, dev_frame_o, dev_frame_oe, irdyn_o_dev, irdyn_oe_dev,
        output trdyn_o_dev, trdyn_oe_dev, stopn_o, stopn_oe, devseln_o, devseln_oe,
        output perrn_o, perrn_oe, serrn_oe, intan_oe, reqn, req64n_o_dev, req64n_oe_dev,
        output ack64n_o, ack64n_oe
    );
    modport hst (
        input  ad, cben, par, par64, framen, irdyn, trdyn, stopn, devseln, perrn,
        input  serrn, intan, reqn, req64n, ack64n,
        output ad_o_hst, cbe_o_hst, ad_oe_hst, ad64_oe_hst, par_o_hst, par64_o_hst,
        output par_oe_hst, framen_o, framen_oe, irdyn_o_hst, irdyn_oe_hst,
        output trdyn_o_hst, trdyn_oe_hst, gntn, idsel, req64n_o_hst, req64n_oe_hst
    );
endinterface

/* rtl/pcisig_dev.sv */
`timescale 1ns/1ps
// Summary of operation
// - Bus timed by one clock up to 66MHz
// - Local side shares the bus clock
// - Active-low reset clears all state asynchronously
// - Lower parity even over ad and cben
// - Upper parity even over upper lanes
// - Initiator drives frame low for the address phase only
// - Initiator and target ready per data phase
// - Target drives stop low to end transfer
// - Addressed target drives device-select low
// - Config cycles claimed only with idsel
// - Request bus before initiating
// - Arbiter grants; no bus without grant
// - Initiator requests 64-bit via req64
// - Target acknowledges 64-bit or stays 32-bit
// - Data parity errors on target writes drive perr low
// - System error open-drain, never driven high
// - Interrupt open-drain, released when l_irq is low
// - Command bits 6 and 8 enable perr, serr
module pcisig_dev (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Bus
    pcisig_if.dev            bus,
    // Local master request
    input  wire logic        l_start,
    input  wire logic        l_write,
    input  wire logic        l_wide,
    input  wire logic [31:0] l_addr,
    input  wire logic [63:0] l_wdata,
    output logic             l_done,
    output logic [63:0]      l_rdata,
    // Local target side
    input  wire logic [31:0] l_bar_base,
    input  wire logic [31:0] l_bar_mask,
    input  wire logic        l_stop_req,
    input  wire logic        l_irq,
    input  wire logic        l_fatal,
    output logic [63:0]      lt_data_out,
    output logic             lt_wr_strobe,
    output logic [15:0]      l_command
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        pcisig_pkg::pcisig_state_e m_st;
        logic        m_write;
        logic        m_wide;
        logic [31:0] m_addr;
        logic [63:0] m_data;
        logic        t_act;
        logic        t_write;
        logic        t_cfg;
        logic        t_wide;
        logic        t_stop;
        logic        t_drive;
        logic [63:0] t_rd;
        logic        chk_pend;
        logic        chk_par;
        logic        perr_q;
        logic        done;
        logic [63:0] rdata;
        logic [63:0] lt_data;
        logic        lt_wr;
        logic [15:0] cmd;
        logic [3:0]  tmo;
        logic        serr;
        logic        par_drv;
        logic [1:0]  par_v;
    } pcisig_dev_s;

    pcisig_dev_s s_q, s_d;
    logic        par_lo, par_hi, addr_hit, cfg_hit, t_claim;

    // Even parity: line equals xor of covered bits
    assign par_lo = ^{bus.ad[31:0], bus.cben[3:0]};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.lt_wr = 1'b0;
        s_d.chk_pend = 1'b0;
        par_hi   = ^{bus.ad[63:32], bus.cben[7:4]};
        addr_hit = ((bus.ad[31:0] & l_bar_mask) == (l_bar_base & l_bar_mask))
                 && (bus.cben[3:0] == pcisig_pkg::CMD_MEM_READ
                 ||  bus.cben[3:0] == pcisig_pkg::CMD_MEM_WRITE);
        cfg_hit  = bus.idsel && (bus.cben[3:0] == pcisig_pkg::CMD_CFG_READ
                 || bus.cben[3:0] == pcisig_pkg::CMD_CFG_WRITE);
        // Address phase: frame just fell while we are not initiator
        t_claim  = !bus.framen && !s_q.t_act && s_q.m_st == pcisig_pkg::ST_IDLE
                 && (addr_hit || cfg_hit);
        if (t_claim)
        begin
            s_d.t_act   = 1'b1;
            s_d.t_write = bus.cben[0];
            s_d.t_cfg   = cfg_hit;
            s_d.t_wide  = !bus.req64n;
            s_d.t_stop  = l_stop_req;
            s_d.t_drive = 1'b0;
        end
        else if (s_q.t_act)
        begin
            s_d.t_drive = !s_q.t_write;
            s_d.t_rd    = s_q.t_cfg ? {48'h0, s_q.cmd} : s_q.lt_data;
            if (l_stop_req)
                s_d.t_stop = 1'b1;
            // Data moves on both readies; a stop ends the phase without data
            if (!bus.irdyn && (!bus.trdyn || s_q.t_stop))
            begin
                if (s_q.t_write && !s_q.t_stop)
                begin
                    // Check data parity next cycle when par arrives
                    s_d.chk_pend = 1'b1;
                    s_d.chk_par  = s_q.t_wide ? (par_lo ^ par_hi) : par_lo;
                    if (s_q.t_cfg)
                        s_d.cmd = bus.ad[15:0];
                    else
                    begin
                        s_d.lt_data = bus.ad;
                        s_d.lt_wr   = 1'b1;
                    end
                end
                if (bus.framen)
                begin
                    s_d.t_act   = 1'b0;
                    s_d.t_drive = 1'b0;
                end
            end
        end
        // Parity verify one cycle after data: even parity means no error
        if (s_q.chk_pend)
            s_d.perr_q = (s_q.chk_par ^ (s_q.t_wide ? (bus.par ^ bus.par64) : bus.par))
                       && s_q.cmd[pcisig_pkg::CMD_PERR_EN_BIT];
        else
            s_d.perr_q = 1'b0;
        // Set wins over the idle-bus clear so an error is never lost
        s_d.serr = (l_fatal && s_q.cmd[pcisig_pkg::CMD_SERR_EN_BIT])
                 || (s_q.serr && !(bus.framen && bus.irdyn));
        // Parity follows its lanes one clock later, from whoever drove them
        s_d.par_drv = s_q.m_st == pcisig_pkg::ST_ADDR || s_q.t_drive
                    || (s_q.m_st == pcisig_pkg::ST_DATA && s_q.m_write);
        s_d.par_v   = {par_hi, par_lo};
        // Initiator
        case (s_q.m_st)
            pcisig_pkg::ST_IDLE:
                if (l_start && !s_q.t_act)
                begin
                    s_d.m_st    = pcisig_pkg::ST_REQ;
                    s_d.m_write = l_write;
                    s_d.m_wide  = l_wide;
                    s_d.m_addr  = l_addr;
                    s_d.m_data  = l_wdata;
                end
            pcisig_pkg::ST_REQ:
                if (!bus.gntn && bus.framen && bus.irdyn)
                    s_d.m_st = pcisig_pkg::ST_ADDR;
            pcisig_pkg::ST_ADDR:
            begin
                s_d.m_st = pcisig_pkg::ST_DATA;
                s_d.tmo  = 4'h0;
            end
            pcisig_pkg::ST_DATA:
            begin
                s_d.tmo = s_q.tmo + 4'h1;
                if (!bus.trdyn || !bus.stopn || s_q.tmo == pcisig_pkg::DEVSEL_TIMEOUT)
                begin
                    s_d.m_st  = pcisig_pkg::ST_TURN;
                    s_d.done  = 1'b1;
                    if (!s_q.m_write)
                        s_d.rdata = bus.ack64n ? {32'h0, bus.ad[31:0]} : bus.ad;
                end
            end
            pcisig_pkg::ST_TURN:
                s_d.m_st = pcisig_pkg::ST_IDLE;
            default:
                s_d.m_st = pcisig_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q       <= '0;
            s_q.m_st  <= pcisig_pkg::ST_IDLE;
            s_q.cmd   <= pcisig_pkg::CMD_RESET;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    logic m_addr_ph, m_data_ph, m_own, wr_data;
    logic [63:0] ad_val;
    logic [7:0]  cbe_val;
    assign m_addr_ph = s_q.m_st == pcisig_pkg::ST_ADDR;
    assign m_data_ph = s_q.m_st == pcisig_pkg::ST_DATA;
    assign m_own     = m_addr_ph || m_data_ph;
    assign wr_data   = m_data_ph && s_q.m_write;
    assign ad_val    = m_addr_ph ? {32'h0, s_q.m_addr} : wr_data ? s_q.m_data : s_q.t_rd;
    assign cbe_val   = m_addr_ph ? {4'h0, (s_q.m_write ? pcisig_pkg::CMD_MEM_WRITE
                                                      : pcisig_pkg::CMD_MEM_READ)} : 8'h00;

    assign bus.reqn         = !(s_q.m_st == pcisig_pkg::ST_REQ);
    assign bus.ad_o_dev     = ad_val;
    assign bus.cbe_o_dev    = cbe_val;
    assign bus.ad_oe_dev    = m_addr_ph || wr_data || s_q.t_drive;
    assign bus.ad64_oe_dev  = (wr_data && s_q.m_wide) || (s_q.t_drive && s_q.t_wide);
    assign bus.par_o_dev    = s_q.par_v[0];
    assign bus.par64_o_dev  = s_q.par_v[1];
    assign bus.par_oe_dev   = s_q.par_drv;
    assign bus.dev_frame_o  = !m_addr_ph;
    assign bus.dev_frame_oe = m_own;
    assign bus.irdyn_o_dev  = !m_data_ph;
    assign bus.irdyn_oe_dev = m_data_ph;
    assign bus.req64n_o_dev = !(m_addr_ph && s_q.m_wide);
    assign bus.req64n_oe_dev = m_own;
    // Read data is registered first, so target ready waits one cycle for it
    assign bus.trdyn_o_dev  = !(s_q.t_write || s_q.t_drive);
    assign bus.trdyn_oe_dev = s_q.t_act && !s_q.t_stop;
    assign bus.stopn_o      = !s_q.t_stop;
    assign bus.stopn_oe     = s_q.t_act;
    assign bus.devseln_o    = 1'b0;
    assign bus.devseln_oe   = s_q.t_act;
    assign bus.ack64n_o     = !s_q.t_wide;
    assign bus.ack64n_oe    = s_q.t_act;
    assign bus.perrn_o      = !s_q.perr_q;
    assign bus.perrn_oe     = s_q.perr_q;
    assign bus.serrn_oe     = s_q.serr;
    assign bus.intan_oe     = l_irq;

    assign l_done       = s_q.done;
    assign l_rdata      = s_q.rdata;
    assign lt_data_out  = s_q.lt_data;
    assign lt_wr_strobe = s_q.lt_wr;
    assign l_command    = s_q.cmd;
endmodule // pcisig_dev

/* rtl/pcisig_hst.sv */
`timescale 1ns/1ps
// Bus host and arbiter end; one transaction at a time
module pcisig_hst (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Bus
    pcisig_if.hst            bus,
    // User side
    input  wire logic        h_start,
    input  wire logic        h_write,
    input  wire logic        h_cfg,
    input  wire logic        h_wide,
    input  wire logic [31:0] h_addr,
    input  wire logic [63:0] h_wdata,
    output logic             h_done,
    output logic [63:0]      h_rdata,
    output logic             h_irq,
    output logic             h_serr
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        pcisig_pkg::pcisig_state_e st;
        logic        write;
        logic        cfg;
        logic        wide;
        logic [31:0] addr;
        logic [63:0] data;
        logic        done;
        logic [63:0] rdata;
        logic [3:0]  tmo;
        logic        gnt;
        logic        par_drv;
        logic [1:0]  par_v;
    } pcisig_hst_s;

    pcisig_hst_s s_q, s_d;
    logic [3:0]  cmd;
    logic        addr_ph, data_ph, wr_ph;

    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.gnt  = !bus.reqn && s_q.st == pcisig_pkg::ST_IDLE;
        s_d.par_drv = addr_ph || wr_ph;
        s_d.par_v   = {^{bus.ad[63:32], bus.cben[7:4]}, ^{bus.ad[31:0], bus.cben[3:0]}};
        case (s_q.st)
            pcisig_pkg::ST_IDLE:
                if (h_start && bus.reqn && bus.framen && bus.irdyn)
                begin
                    s_d.st    = pcisig_pkg::ST_ADDR;
                    s_d.write = h_write;
                    s_d.cfg   = h_cfg;
                    s_d.wide  = h_wide;
                    s_d.addr  = h_addr;
                    s_d.data  = h_wdata;
                    s_d.gnt   = 1'b0;
                end
            pcisig_pkg::ST_ADDR:
            begin
                s_d.st  = pcisig_pkg::ST_DATA;
                s_d.tmo = 4'h0;
            end
            pcisig_pkg::ST_DATA:
            begin
                s_d.tmo = s_q.tmo + 4'h1;
                if (!bus.trdyn || !bus.stopn || s_q.tmo == pcisig_pkg::DEVSEL_TIMEOUT)
                begin
                    s_d.st   = pcisig_pkg::ST_TURN;
                    s_d.done = 1'b1;
                    if (!s_q.write)
                        s_d.rdata = bus.ack64n ? {32'h0, bus.ad[31:0]} : bus.ad;
                end
            end
            default:
                s_d.st = pcisig_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q    <= '0;
            s_q.st <= pcisig_pkg::ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    assign addr_ph = s_q.st == pcisig_pkg::ST_ADDR;
    assign data_ph = s_q.st == pcisig_pkg::ST_DATA;
    assign wr_ph   = data_ph && s_q.write;
    assign cmd     = s_q.cfg ? (s_q.write ? pcisig_pkg::CMD_CFG_WRITE : pcisig_pkg::CMD_CFG_READ)
                             : (s_q.write ? pcisig_pkg::CMD_MEM_WRITE : pcisig_pkg::CMD_MEM_READ);

    assign bus.gntn          = !s_q.gnt;
    assign bus.idsel         = addr_ph && s_q.cfg;
    assign bus.ad_o_hst      = addr_ph ? {32'h0, s_q.addr} : s_q.data;
    assign bus.cbe_o_hst     = addr_ph ? {4'h0, cmd} : 8'h00;
    assign bus.ad_oe_hst     = addr_ph || wr_ph;
    assign bus.ad64_oe_hst   = wr_ph && s_q.wide;
    assign bus.par_o_hst     = s_q.par_v[0];
    assign bus.par64_o_hst   = s_q.par_v[1];
    assign bus.par_oe_hst    = s_q.par_drv;
    assign bus.framen_o      = !addr_ph;
    assign bus.framen_oe     = addr_ph || data_ph;
    assign bus.irdyn_o_hst   = !data_ph;
    assign bus.irdyn_oe_hst  = data_ph;
    assign bus.trdyn_o_hst   = 1'b1;
    assign bus.trdyn_oe_hst  = 1'b0;
    assign bus.req64n_o_hst  = !(addr_ph && s_q.wide);
    assign bus.req64n_oe_hst = addr_ph || data_ph;

    assign h_done  = s_q.done;
    assign h_rdata = s_q.rdata;
    assign h_irq   = !bus.intan;
    assign h_serr  = !bus.serrn;
endmodule // pcisig_hst

/* test/pcisig_asserts.sv */
`timescale 1ns/1ps
module pcisig_asserts (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // Bus lines
    input wire logic       framen,
    input wire logic       irdyn,
    input wire logic       trdyn,
    input wire logic       stopn,
    input wire logic       devseln,
    input wire logic       reqn,
    input wire logic       gntn,
    input wire logic       idsel,
    input wire logic       ack64n,
    input wire logic [7:0] cben,
    input wire logic [31:0] ad,
    input wire logic       par,
    input wire logic       perrn,
    // Drive enables
    input wire logic       ad_oe_dev,
    input wire logic       ad_oe_hst,
    input wire logic       trdyn_oe_dev,
    input wire logic       dev_frame_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // Bus checks
    // ----------------------------------------------------------------
    one_owner_a: assert property (!(ad_oe_dev && ad_oe_hst))
        else $error("both ends drive ad");
    frame_short_a: assert property ($fell(framen) |-> ##[1:8] framen)
        else $error("frame held too long");
    frame_end_a: assert property ($rose(framen) |-> !irdyn)
        else $error("frame released without initiator ready");
    irdy_bound_a: assert property ($fell(irdyn) |-> ##[1:10] irdyn)
        else $error("initiator ready stuck");
    devsel_cause_a: assert property ($fell(devseln) |-> !$past(framen))
        else $error("device select without address phase");
    cfg_idsel_a: assert property (($fell(framen) && cben[3:1] == 3'h5 && !idsel)
        |=> devseln [*3]) else $error("config claimed without idsel");
    stop_phase_a: assert property (!stopn |-> !irdyn && !devseln)
        else $error("stop outside a claimed data phase");
    trdy_claim_a: assert property ((trdyn_oe_dev && !trdyn) |-> !devseln)
        else $error("target ready without device select");
    ack64_claim_a: assert property (!ack64n |-> !devseln)
        else $error("wide acknowledge without device select");
    grant_first_a: assert property ($rose(dev_frame_oe) |-> !$past(gntn))
        else $error("frame driven without grant");
    req_first_a: assert property ($fell(gntn) |-> !$past(reqn))
        else $error("grant without request");
    cfg_claim_a: assert property ($fell(framen) && cben[3:1] == 3'h5 && idsel
        |=> !devseln) else $error("config cycle with idsel not claimed");
    par_even_a: assert property ((ad_oe_dev || ad_oe_hst)
        |=> par == $past(^{ad, cben[3:0]})) else $error("parity not even over lower lanes");
    perr_quiet_a: assert property (perrn)
        else $error("parity error reported on a clean bus");
endmodule // pcisig_asserts

/* test/test_pci_bus_side_signalling.sv */
`timescale 1ns/1ps
module test_pci_bus_side_signalling;
    logic        clk_sys = 1'b0, nrst = 1'b0;
    logic        h_start = 1'b0, h_write = 1'b0, h_cfg = 1'b0, h_wide = 1'b0;
    logic [31:0] h_addr = 32'h0, l_addr = 32'h0;
    logic [63:0] h_wdata = 64'h0, l_wdata = 64'h0;
    logic        l_start = 1'b0, l_write = 1'b0, l_wide = 1'b0, l_stop_req = 1'b0;
    logic        l_irq = 1'b0, l_fatal = 1'b0;
    logic [31:0] l_bar_base = 32'h4000_0000, l_bar_mask = 32'hF000_0000;
    logic        h_done, h_irq, h_serr, l_done, lt_wr_strobe;
    logic [63:0] h_rdata, l_rdata, lt_data_out, d, mem_m;
    logic [15:0] l_command, cmd_m, seed = 16'h22FC;
    logic [31:0] a;
    int          n_errors = 0, n_tests = 0, cycles = 0, n_strobe = 0, s0 = 0;
    logic        saw_stop = 1'b0, saw_serr = 1'b0;

    pcisig_if  bus ();
    pcisig_dev u_pcisig_dev (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .l_start(l_start), .l_write(l_write),
        .l_wide(l_wide), .l_addr(l_addr), .l_wdata(l_wdata), .l_done(l_done), .l_rdata(l_rdata),
        .l_bar_base(l_bar_base), .l_bar_mask(l_bar_mask), .l_stop_req(l_stop_req),
        .l_irq(l_irq), .l_fatal(l_fatal), .lt_data_out(lt_data_out),
        .lt_wr_strobe(lt_wr_strobe), .l_command(l_command)
    );
    pcisig_hst u_pcisig_hst (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .h_start(h_start), .h_write(h_write),
        .h_cfg(h_cfg), .h_wide(h_wide), .h_addr(h_addr), .h_wdata(h_wdata), .h_done(h_done),
        .h_rdata(h_rdata), .h_irq(h_irq), .h_serr(h_serr)
    );
    pcisig_asserts u_pcisig_asserts (
        .clk_sys(clk_sys), .nrst(nrst), .framen(bus.framen), .irdyn(bus.irdyn),
        .trdyn(bus.trdyn), .stopn(bus.stopn), .devseln(bus.devseln), .reqn(bus.reqn),
        .gntn(bus.gntn), .idsel(bus.idsel), .ack64n(bus.ack64n), .cben(bus.cben),
        .ad_oe_dev(bus.ad_oe_dev), .ad_oe_hst(bus.ad_oe_hst),
        .trdyn_oe_dev(bus.trdyn_oe_dev), .dev_frame_oe(bus.dev_frame_oe),
        .ad(bus.ad[31:0]), .par(bus.par), .perrn(bus.perrn)
    );

    always #25 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Monitors and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        n_strobe <= n_strobe + (lt_wr_strobe === 1'b1);
        if (bus.stopn === 1'b0)
            saw_stop <= 1'b1;
        if (h_serr === 1'b1)
            saw_serr <= 1'b1;
        if (cycles == 6000)
        begin
            n_errors++;
            stop_test();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk64({63'h0, got}, {63'h0, exp}, what);
    endtask

    // Host transfer; the bus turns round before the next one
    task automatic htx(input logic cfg, wr, wide, input logic [31:0] ad, input logic [63:0] wd);
        int i;
        @(posedge clk_sys);
        h_cfg   <= cfg;
        h_write <= wr;
        h_wide  <= wide;
        h_addr  <= ad;
        h_wdata <= wd;
        h_start <= 1'b1;
        @(posedge clk_sys);
        h_start <= 1'b0;
        for (i = 0; i < 40 && h_done !== 1'b1; i++)
            @(negedge clk_sys);
        chk1(h_done, 1'b1, "host done");
        repeat (2)
            @(posedge clk_sys);
    endtask

    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        int i;
        repeat (6)
            @(negedge clk_sys);
        chk1(bus.reqn, 1'b1, "request in reset");
        chk64({48'h0, l_command}, 64'h0, "command in reset");
        @(posedge clk_sys);
        nrst <= 1'b1;
        // System error enable off, then on; parity, space and master enables kept set
        for (int k = 0; k < 2; k++)
        begin
            seed = lfsr(seed);
            cmd_m = {7'h00, k[0], 1'b0, 1'b1, seed[5:3], 3'h7};
            htx(1'b1, 1'b1, 1'b0, 32'h4, {48'h0, cmd_m});
            chk64({48'h0, l_command}, {48'h0, cmd_m}, "command");
            htx(1'b1, 1'b0, 1'b0, 32'h4, 64'h0);
            chk64({48'h0, h_rdata[15:0]}, {48'h0, cmd_m}, "config read");
            l_fatal <= 1'b1;
            saw_serr = 1'b0;
            htx(1'b0, 1'b1, 1'b0, 32'h5000_0000, 64'h0);
            chk1(saw_serr, k[0], "system error");
            l_fatal <= 1'b0;
        end
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            d = {seed, ~seed, seed ^ 16'h5A5A, seed};
            a = {k[0] ? 4'h5 : 4'h4, 12'h000, seed};
            s0 = n_strobe;
            htx(1'b0, !k[2], k[1], a, d);
            chk1(n_strobe - s0 == 1,
                 ((a ^ l_bar_base) & l_bar_mask) == 0 && !k[2], "strobe");
            if (!k[0] && !k[2])
                chk64(k[1] ? lt_data_out : {32'h0, lt_data_out[31:0]},
                      k[1] ? d : {32'h0, d[31:0]}, "target data");
            // Model: last hit write is what a hit read returns
            if (!k[0] && !k[2])
                mem_m = d;
            if (!k[0] && k[2])
                chk64(h_rdata, k[1] ? mem_m : {32'h0, mem_m[31:0]}, "target read");
        end
        l_stop_req <= 1'b1;
        saw_stop = 1'b0;
        htx(1'b0, 1'b1, 1'b0, 32'h4000_0010, d);
        chk1(saw_stop, 1'b1, "target stop");
        l_stop_req <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            seed = lfsr(seed);
            l_write <= k[0];
            l_wide  <= k[0];
            l_addr  <= {16'h6000, seed};
            l_wdata <= {4{seed}};
            l_start <= 1'b1;
            @(posedge clk_sys);
            l_start <= 1'b0;
            for (i = 0; i < 40 && l_done !== 1'b1; i++)
                @(negedge clk_sys);
            chk1(l_done, 1'b1, "master done");
            @(posedge clk_sys);
        end
        l_irq <= 1'b1;
        repeat (3)
            @(negedge clk_sys);
        chk1(h_irq, 1'b1, "interrupt raised");
        @(posedge clk_sys);
        l_irq <= 1'b0;
        repeat (3)
            @(negedge clk_sys);
        chk1(h_irq, 1'b0, "interrupt released");
        stop_test();
    end
endmodule // test_pci_bus_side_signalling
